// ===== inc/rgos_map.svh
/*
  Register offsets, field positions, reset values and limits of the regeneration
  overload supervisor.
  Assumes inclusion by bare name from the package; the design files use its macros without including it.
*/
`ifndef RGOS_MAP_SVH
`define RGOS_MAP_SVH

// Byte offsets of the word registers.
`define RGOS_OFS_CTRL 8'h00
`define RGOS_OFS_RES_OHM 8'h04
`define RGOS_OFS_MAX_POWER 8'h08
`define RGOS_OFS_POWER 8'h0c
`define RGOS_OFS_IRQ_STAT 8'h10
`define RGOS_OFS_IRQ_MASK 8'h14
`define RGOS_OFS_STATE 8'h18

// Control register fields.
`define RGOS_CTRL_CHECK_BIT 0
`define RGOS_CTRL_REACT_BIT 1
`define RGOS_CTRL_RESET 2'h1

// Interrupt status fields.
`define RGOS_IRQ_EXCESS_BIT 0
`define RGOS_IRQ_LOG_BIT 1
`define RGOS_IRQ_PARAM_BIT 2
`define RGOS_IRQ_WIDTH 3

// Parameter widths, accepted ranges and plain reset defaults.
`define RGOS_OHM_W 7
`define RGOS_PWR_W 14
`define RGOS_OHM_MIN 7'h04
`define RGOS_OHM_MAX 7'h64
`define RGOS_OHM_RESET 7'h0a
`define RGOS_PWR_MIN 14'h000a
`define RGOS_PWR_MAX 14'h2710
`define RGOS_PWR_RESET 14'h00c8

`endif

// ===== inc/rgos_pkg.sv
/*
  Types shared by the regeneration overload supervisor and its stop sequencer.
  Assumes the map header is on the include path.
*/
package rgos_pkg;
  `include "rgos_map.svh"

  // Register port request, one cycle per access.
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } rgos_bus_req_type;

  // Display code shown for the regeneration condition.
  typedef enum logic [1:0] {
    RGOS_DISP_NONE = 2'h0,
    RGOS_DISP_ACTIVE = 2'h1,
    RGOS_DISP_HELD = 2'h2
  } rgos_disp_type;

  // Error log message codes.
  typedef enum logic [1:0] {
    RGOS_LOG_NONE = 2'h0,
    RGOS_LOG_WARNING = 2'h1,
    RGOS_LOG_EXCEEDED = 2'h2
  } rgos_log_type;

  // Error log write, valid for one cycle.
  typedef struct packed {
    logic valid;
    rgos_log_type code;
  } rgos_log_type_s_type;

  // Stop sequencer states, one-hot.
  typedef enum logic [2:0] {
    RGOS_SEQ_RUN = 3'h1,
    RGOS_SEQ_STOP = 3'h2,
    RGOS_SEQ_OFF = 3'h4
  } rgos_seq_type;
endpackage : rgos_pkg

// ===== hdl/rgos_stop_seq.sv
/*
  Quick stop then disable sequencer for a latched regeneration fault.
  Assumes the motion logic acknowledges the finished quick stop with a level or pulse.
*/
module rgos_stop_seq (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_trigger,
  input wire logic i_stop_done,
  input wire logic i_clear,
  output logic o_quick_stop,
  output logic o_drive_disable
);
  import rgos_pkg::*;

  rgos_seq_type state_r;
  rgos_seq_type state_nxt;

  // Next state: a stop runs to completion before the drive is turned off.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      RGOS_SEQ_RUN: begin
        if (i_trigger) begin
          state_nxt = RGOS_SEQ_STOP;
        end
      end
      RGOS_SEQ_STOP: begin
        if (i_stop_done) begin
          state_nxt = RGOS_SEQ_OFF;
        end
      end
      RGOS_SEQ_OFF: begin
        if (i_clear) begin
          state_nxt = RGOS_SEQ_RUN;
        end
      end
      default: begin
        state_nxt = RGOS_SEQ_RUN;
      end
    endcase
  end

  // State register.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_r <= RGOS_SEQ_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs decode straight from one-hot flops, so they are glitch free.
  assign o_quick_stop = state_r[1];
  assign o_drive_disable = state_r[2];
endmodule : rgos_stop_seq

// ===== hdl/rgos_supervisor.sv
/*
  Regeneration overload supervisor: compares calculated continuous regeneration
  power against the configured maximum and reacts by warning or by stop and disable.
  Assumes power figures, enable request and thermal flags are synchronous to i_clk.
*/
// Operation
// - Block internal resistor current once its continuous capability is exceeded.
// - Warning mode: excess turns thermal limit output off, shows active code.
// - Warning mode does not latch: output and code recover when power drops.
// - Warning mode logs only the first excess after each drive enable.
// - Disable mode: output off, active code, quick stop, then disable.
// - Disable mode latches fault, held code shown until next enable.
// - Disable mode: output returns on once power no longer exceeds.
// - Disable mode writes a regeneration exceeded log message.
// - Supervision switched off: excess causes no action whatsoever.
// - Supervision defaults on; reaction selected by a configuration command.
// - Thermal limit output also shows thermal torque limitation.
// - Resistance accepted only within 4 to 100 ohms.
// - Maximum continuous power accepted only within 10 to 10000 W.
// - Calculated power stays readable whether supervision is on or off.
module rgos_supervisor (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire rgos_pkg::rgos_bus_req_type i_bus,
  output logic [31:0] o_rdata,
  input wire logic [13:0] i_calc_power,
  input wire logic i_int_overload,
  input wire logic i_thermal_torque_limit,
  input wire logic i_drive_enable_req,
  input wire logic i_stop_done,
  output logic o_thermal_limit_output,
  output rgos_pkg::rgos_disp_type o_display,
  output rgos_pkg::rgos_log_type_s_type o_log,
  output logic o_int_resistor_block,
  output logic o_quick_stop,
  output logic o_drive_disable,
  output logic o_irq
);
  import rgos_pkg::*;

  // Range check shared by both parameter registers.
  function automatic logic in_range(input logic [13:0] v, input logic [13:0] lo,
                                    input logic [13:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  logic [1:0] ctrl_r;
  logic [`RGOS_OHM_W-1:0] ohm_r;
  logic [`RGOS_PWR_W-1:0] max_pwr_r;
  logic [`RGOS_IRQ_WIDTH-1:0] irq_stat_r;
  logic [`RGOS_IRQ_WIDTH-1:0] irq_mask_r;
  logic [31:0] rdata_r;
  logic enable_q_r;
  logic excess_q_r;
  logic latched_r;
  logic logged_r;
  logic tl_out_r;
  logic block_r;
  rgos_disp_type disp_r;
  rgos_log_type_s_type log_r;

  // Address decode of the register port.
  wire wr_ctrl = i_bus.wr && (i_bus.addr == `RGOS_OFS_CTRL);
  wire wr_ohm = i_bus.wr && (i_bus.addr == `RGOS_OFS_RES_OHM);
  wire wr_pwr = i_bus.wr && (i_bus.addr == `RGOS_OFS_MAX_POWER);
  wire wr_stat = i_bus.wr && (i_bus.addr == `RGOS_OFS_IRQ_STAT);
  wire wr_mask = i_bus.wr && (i_bus.addr == `RGOS_OFS_IRQ_MASK);

  // Parameter values are checked before they are accepted.
  wire [13:0] ohm_wide = {7'h00, i_bus.wdata[6:0]};
  wire [13:0] ohm_lo = {7'h00, `RGOS_OHM_MIN};
  wire [13:0] ohm_hi = {7'h00, `RGOS_OHM_MAX};
  wire ohm_hi_zero = (i_bus.wdata[31:7] == 25'h0000000);
  wire ohm_ok = ohm_hi_zero && in_range(ohm_wide, ohm_lo, ohm_hi);
  wire pwr_hi_zero = (i_bus.wdata[31:14] == 18'h00000);
  wire pwr_ok = pwr_hi_zero &&
                in_range(i_bus.wdata[13:0], `RGOS_PWR_MIN, `RGOS_PWR_MAX);
  wire param_reject = (wr_ohm && !ohm_ok) || (wr_pwr && !pwr_ok);

  // Supervision and reaction selection.
  wire check_on = ctrl_r[`RGOS_CTRL_CHECK_BIT];
  wire react_disable = ctrl_r[`RGOS_CTRL_REACT_BIT];

  // Excess is only seen while supervision is on, so a switched-off check is inert.
  wire excess = check_on && (i_calc_power > max_pwr_r);
  wire excess_rise = excess && !excess_q_r;
  wire enable_rise = i_drive_enable_req && !enable_q_r;

  // A rising enable starts a new logging window and may release the latch.
  wire latch_clear = enable_rise && !excess;
  wire latch_set = excess_rise && react_disable;

  // Warning mode logs once per enable; disable mode logs every new fault.
  wire log_warn = excess_rise && !react_disable && (!logged_r || enable_rise);
  wire log_exc = latch_set && !latched_r;

  // Interrupt events.
  wire [`RGOS_IRQ_WIDTH-1:0] irq_event = {param_reject, log_warn || log_exc, excess_rise};

  // Control register, supervision on after reset.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctrl_r <= `RGOS_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_r <= i_bus.wdata[1:0];
    end
  end

  // Resistor parameters keep their old value when a write is out of range.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ohm_r <= `RGOS_OHM_RESET;
      max_pwr_r <= `RGOS_PWR_RESET;
    end else begin
      if (wr_ohm && ohm_ok) begin
        ohm_r <= i_bus.wdata[6:0];
      end
      if (wr_pwr && pwr_ok) begin
        max_pwr_r <= i_bus.wdata[13:0];
      end
    end
  end

  // Sticky status: an event in the clearing cycle survives the clear.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      irq_stat_r <= 3'h0;
      irq_mask_r <= 3'h0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~(wr_stat ? i_bus.wdata[2:0] : 3'h0)) | irq_event;
      if (wr_mask) begin
        irq_mask_r <= i_bus.wdata[2:0];
      end
    end
  end

  assign o_irq = |(irq_stat_r & irq_mask_r);

  // Edge history for enable and excess.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      enable_q_r <= 1'b0;
      excess_q_r <= 1'b0;
    end else begin
      enable_q_r <= i_drive_enable_req;
      excess_q_r <= excess;
    end
  end

  // Latched fault, kept across a later switch to warning mode on purpose.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      latched_r <= 1'b0;
    end else if (latch_set) begin
      latched_r <= 1'b1;
    end else if (latch_clear) begin
      latched_r <= 1'b0;
    end
  end

  // Logging window: set by the first warning, reopened by each enable.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      logged_r <= 1'b0;
    end else if (log_warn) begin
      logged_r <= 1'b1;
    end else if (enable_rise) begin
      logged_r <= 1'b0;
    end
  end

  // Log port, one cycle per message.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      log_r <= '{valid: 1'b0, code: RGOS_LOG_NONE};
    end else if (log_exc) begin
      log_r <= '{valid: 1'b1, code: RGOS_LOG_EXCEEDED};
    end else if (log_warn) begin
      log_r <= '{valid: 1'b1, code: RGOS_LOG_WARNING};
    end else begin
      log_r <= '{valid: 1'b0, code: RGOS_LOG_NONE};
    end
  end

  assign o_log = log_r;

  // Display code: the live excess wins over the held indication.
  wire rgos_disp_type disp_nxt = excess ? RGOS_DISP_ACTIVE :
                                 (latched_r && !latch_clear) ? RGOS_DISP_HELD :
                                 RGOS_DISP_NONE;

  // The output follows power and the torque limit, never the latch, so a controller can re-enable.
  wire tl_nxt = !(excess || i_thermal_torque_limit);

  // Pin-facing outputs come from flops.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      disp_r <= RGOS_DISP_NONE;
      tl_out_r <= 1'b1;
      block_r <= 1'b0;
    end else begin
      disp_r <= disp_nxt;
      tl_out_r <= tl_nxt;
      block_r <= i_int_overload;
    end
  end

  assign o_display = disp_r;
  assign o_thermal_limit_output = tl_out_r;
  assign o_int_resistor_block = block_r;

  // Quick stop then disable on a fault in disable mode.
  rgos_stop_seq u_stop_seq (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_trigger(latch_set),
    .i_stop_done(i_stop_done),
    .i_clear(latch_clear),
    .o_quick_stop(o_quick_stop),
    .o_drive_disable(o_drive_disable)
  );

  // Read mux; unmapped addresses read as zero.
  wire [31:0] state_word = {26'h0000000, disp_r, tl_out_r, latched_r, excess_q_r, block_r};
  wire [31:0] rd_mux =
    (i_bus.addr == `RGOS_OFS_CTRL) ? {30'h00000000, ctrl_r} :
    (i_bus.addr == `RGOS_OFS_RES_OHM) ? {25'h0000000, ohm_r} :
    (i_bus.addr == `RGOS_OFS_MAX_POWER) ? {18'h00000, max_pwr_r} :
    (i_bus.addr == `RGOS_OFS_POWER) ? {18'h00000, i_calc_power} :
    (i_bus.addr == `RGOS_OFS_IRQ_STAT) ? {29'h00000000, irq_stat_r} :
    (i_bus.addr == `RGOS_OFS_IRQ_MASK) ? {29'h00000000, irq_mask_r} :
    (i_bus.addr == `RGOS_OFS_STATE) ? state_word :
    32'h00000000;

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rdata_r <= 32'h00000000;
    end else if (i_bus.rd) begin
      rdata_r <= rd_mux;
    end else begin
      rdata_r <= 32'h00000000;
    end
  end

  assign o_rdata = rdata_r;
endmodule : rgos_supervisor

// ===== tb/rgos_supervisor_monitor.sv
/*
  Port checker for the regeneration overload supervisor, bound into it.
  Assumes one clock and the synchronous active-high reset.
*/
module rgos_supervisor_monitor (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_int_overload,
  input wire logic i_thermal_torque_limit,
  input wire logic i_drive_enable_req,
  input wire logic i_stop_done,
  input wire logic o_thermal_limit_output,
  input wire rgos_pkg::rgos_disp_type o_display,
  input wire rgos_pkg::rgos_log_type_s_type o_log,
  input wire logic o_int_resistor_block,
  input wire logic o_quick_stop,
  input wire logic o_drive_disable
);
  import rgos_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);

  // Outputs are tied to their causes with the one-edge latency of the design.
  property p_blk;
    i_int_overload |=> o_int_resistor_block;
  endproperty
  a_blk: assert property (p_blk) else $error("resistor not blocked");
  property p_act;
    o_display == RGOS_DISP_ACTIVE |-> !o_thermal_limit_output;
  endproperty
  a_act: assert property (p_act) else $error("limit output on during excess");
  property p_trq;
    i_thermal_torque_limit |=> !o_thermal_limit_output;
  endproperty
  a_trq: assert property (p_trq) else $error("torque limit not shown");
  property p_lg;
    o_log.valid |-> (o_log.code != RGOS_LOG_NONE) ##1 !o_log.valid;
  endproperty
  a_lg: assert property (p_lg) else $error("bad log pulse");
  property p_qs;
    $rose(o_quick_stop) |-> o_display == RGOS_DISP_ACTIVE && !o_thermal_limit_output;
  endproperty
  a_qs: assert property (p_qs) else $error("quick stop without excess");
  property p_dis;
    o_quick_stop && i_stop_done |=> o_drive_disable && !o_quick_stop;
  endproperty
  a_dis: assert property (p_dis) else $error("no disable after stop");
  property p_hold;
    o_drive_disable && !$rose(i_drive_enable_req) |=> o_drive_disable;
  endproperty
  a_hold: assert property (p_hold) else $error("latch lost");
  property p_held;
    o_display == RGOS_DISP_HELD && !$rose(i_drive_enable_req) |=> o_display != RGOS_DISP_NONE;
  endproperty
  a_held: assert property (p_held) else $error("held code dropped");
  // A held code means power is back under the maximum, so the output must be on again.
  property p_rel;
    o_display == RGOS_DISP_HELD && !$past(i_thermal_torque_limit) |-> o_thermal_limit_output;
  endproperty
  a_rel: assert property (p_rel) else $error("limit output off while held");

  // Main scenarios reached.
  c_qs: cover property ($rose(o_quick_stop));
  c_held: cover property (o_display == RGOS_DISP_HELD);
  c_log: cover property (o_log.valid);
endmodule : rgos_supervisor_monitor

bind rgos_supervisor rgos_supervisor_monitor i_rgos_supervisor_monitor (
  .i_clk(i_clk),
  .i_reset(i_reset),
  .i_int_overload(i_int_overload),
  .i_thermal_torque_limit(i_thermal_torque_limit),
  .i_drive_enable_req(i_drive_enable_req),
  .i_stop_done(i_stop_done),
  .o_thermal_limit_output(o_thermal_limit_output),
  .o_display(o_display),
  .o_log(o_log),
  .o_int_resistor_block(o_int_resistor_block),
  .o_quick_stop(o_quick_stop),
  .o_drive_disable(o_drive_disable)
);

// ===== tb/rgos_plc_model.sv
/*
  Controller model: acknowledges a quick stop after a chosen delay.
  Assumes the bench sets the delay between episodes.
*/
module rgos_plc_model (
  input wire logic i_clk,
  input wire logic i_quick_stop,
  input wire logic i_thermal,
  input wire logic [3:0] i_delay,
  output logic o_stop_done,
  output logic o_reduce_stress
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r = 4'h0;
  initial o_stop_done = 1'h0;

  // Counting from the stop request models a slow or prompt ramp-down.
  always @(posedge i_clk) begin
    cnt_r <= i_quick_stop ? cnt_r + 4'h1 : 4'h0;
    o_stop_done <= i_quick_stop && cnt_r == i_delay;
  end

  // The controller backs off thermal stress while the limit output is low.
  assign o_reduce_stress = !i_thermal;
endmodule : rgos_plc_model

// ===== tb/tb_rgos_supervisor.sv
/*
  Self-checking bench for the regeneration overload supervisor.
  Assumes the controller model acknowledges quick stops.
*/
module tb_rgos_supervisor import rgos_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'h0;
  logic i_reset = 1'h1;
  rgos_bus_req_type i_bus = '0;
  logic [13:0] i_calc_power = 14'h0;
  logic i_int_overload = 1'h0;
  logic i_thermal_torque_limit = 1'h0;
  logic i_drive_enable_req = 1'h0;
  logic i_stop_done;
  logic [31:0] o_rdata;
  logic o_thermal_limit_output, o_int_resistor_block, o_quick_stop, o_drive_disable, o_irq;
  rgos_disp_type o_display;
  rgos_log_type_s_type o_log;
  logic [3:0] delay = 4'h0;
  logic rd_d = 1'h0;
  logic [31:0] rd_q[$];
  logic [31:0] lg_q[$];
  logic [13:0] pv;
  int miscompares = 0;
  int samples_checked = 0;
  int tv[8] = '{3, 4, 101, 100, 9, 10, 10001, 10000};
  int te[8] = '{10, 4, 4, 100, 200, 10, 10, 10000};

  rgos_supervisor i_rgos_supervisor (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_bus(i_bus),
    .o_rdata(o_rdata),
    .i_calc_power(i_calc_power),
    .i_int_overload(i_int_overload),
    .i_thermal_torque_limit(i_thermal_torque_limit),
    .i_drive_enable_req(i_drive_enable_req),
    .i_stop_done(i_stop_done),
    .o_thermal_limit_output(o_thermal_limit_output),
    .o_display(o_display),
    .o_log(o_log),
    .o_int_resistor_block(o_int_resistor_block),
    .o_quick_stop(o_quick_stop),
    .o_drive_disable(o_drive_disable),
    .o_irq(o_irq)
  );
  rgos_plc_model i_rgos_plc_model (.i_clk, .i_quick_stop(o_quick_stop),
    .i_thermal(o_thermal_limit_output), .i_delay(delay), .o_stop_done(i_stop_done),
    .o_reduce_stress());

  // Free-running clock of 10 ns.
  always #5 i_clk = ~i_clk;

  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp_word

  task automatic cmp_pin(input logic [1:0] g, input logic [1:0] e);
    cmp_word(32'(g), 32'(e));
  endtask : cmp_pin

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_bus <= '{a, d, 1'h1, 1'h0};
    @(posedge i_clk);
    i_bus <= '0;
  endtask : wr

  // The expected word is noted before the strobe so the watcher finds it.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    @(posedge i_clk);
    i_bus <= '{a, 32'h0, 1'h0, 1'h1};
    @(posedge i_clk);
    i_bus <= '0;
  endtask : rd

  task automatic drv(input logic [13:0] p, input logic e);
    @(posedge i_clk);
    i_calc_power <= p;
    i_drive_enable_req <= e;
    cyc(1);
  endtask : drv

  task automatic st(input logic t, input logic [1:0] d);
    cmp_pin(2'(o_display == RGOS_DISP_ACTIVE && o_thermal_limit_output), 2'h0);
    cmp_pin(2'(o_thermal_limit_output), {1'h0, t});
    cmp_pin(o_display, d);
  endtask : st

  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  // Read data and log entries are compared with the oldest note as they appear.
  always @(posedge i_clk) begin
    if (rd_d) cmp_word(o_rdata, rd_q.pop_front());
    if (o_log.valid === 1'h1) cmp_word(32'(o_log.code), lg_q.pop_front());
    rd_d <= i_bus.rd;
  end

  // Main sequence; each warning-mode excess above 200 W is one past the default.
  initial begin
    void'($urandom(10195));
    repeat (2) @(posedge i_clk);
    i_reset <= 1'h0;
    rd(8'h00, 32'h1);
    rd(8'h1c, 32'h0);
    for (int k = 0; k < 8; k++) begin
      wr(k < 4 ? 8'h04 : 8'h08, 32'(tv[k]));
      rd(k < 4 ? 8'h04 : 8'h08, 32'(te[k]));
    end
    wr(8'h08, 32'hc8);
    $display("test ranges done");
    wr(8'h00, 32'h0);
    pv = 14'($urandom_range(16383, 201));
    drv(pv, 1'h0);
    st(1'h1, 2'h0);
    rd(8'h0c, 32'(pv));
    // Power drops before supervision returns, or the stale excess would log unexpectedly.
    drv(14'h0, 1'h1);
    wr(8'h00, 32'h1);
    $display("test off done");
    lg_q.push_back(32'h1);
    drv(14'h0c9, 1'h1);
    st(1'h0, 2'h1);
    drv(14'h0c8, 1'h1);
    st(1'h1, 2'h0);
    drv(14'h0c9, 1'h1);
    st(1'h0, 2'h1);
    drv(14'h0, 1'h1);
    rd(8'h10, 32'h7);
    cyc(0);
    cmp_pin(2'(o_irq), 2'h0);
    wr(8'h14, 32'h1);
    cyc(0);
    cmp_pin(2'(o_irq), 2'h1);
    wr(8'h10, 32'h7);
    cyc(0);
    cmp_pin(2'(o_irq), 2'h0);
    @(posedge i_clk);
    i_thermal_torque_limit <= 1'h1;
    i_int_overload <= 1'h1;
    cyc(1);
    st(1'h0, 2'h0);
    cmp_pin(2'(o_int_resistor_block), 2'h1);
    @(posedge i_clk);
    i_thermal_torque_limit <= 1'h0;
    i_int_overload <= 1'h0;
    $display("test warning done");
    wr(8'h00, 32'h3);
    for (int k = 0; k < 2; k++) begin
      delay <= 4'(k * 5);
      lg_q.push_back(32'h2);
      drv(14'h0c9, 1'h1);
      st(1'h0, 2'h1);
      cmp_pin(2'(o_quick_stop), 2'h1);
      cyc(12);
      cmp_pin(2'(o_drive_disable), 2'h1);
      drv(14'h0c9, 1'h0);
      drv(14'h0c9, 1'h1);
      cmp_pin(2'(o_drive_disable), 2'h1);
      drv(14'h0, 1'h1);
      st(1'h1, 2'h2);
      drv(14'h0, 1'h0);
      drv(14'h0, 1'h1);
      st(1'h1, 2'h0);
      cmp_pin(2'(o_drive_disable), 2'h0);
    end
    cmp_word(32'(lg_q.size()), 32'h0);
    $display("test disable done");
    tally_and_finish;
  end

  // Watchdog far beyond the little over one microsecond the tests need.
  initial begin
    #50us;
    miscompares++;
    tally_and_finish;
  end
endmodule : tb_rgos_supervisor
